// *** common/adcmx_pkg.sv ***
package adcmx_pkg;
    // byte addresses inside the slave window (haddr[7:0])
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MUX = 8'h04;
    localparam logic [7:0] ADDR_TRIG = 8'h08;
    localparam logic [7:0] ADDR_RES_LO = 8'h0c;
    localparam logic [7:0] ADDR_RES_HI = 8'h10;
    localparam logic [7:0] ADDR_EVT_STAT = 8'h14;
    localparam logic [7:0] ADDR_EVT_MASK = 8'h18;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // conversion_control_status fields
    localparam int CTRL_EN = 7;
    localparam int CTRL_START = 6;
    localparam int CTRL_AUTO = 5;
    localparam int CTRL_FLAG = 4;
    localparam int CTRL_IE = 3;
    // input_reference_select fields
    localparam int MUX_ADJ = 5;
    localparam logic [1:0] REF_EXT = 2'h0;
    localparam logic [1:0] REF_INT = 2'h3;
    localparam logic [2:0] TS_FREE = 3'h0;
    // event status / mask bits
    localparam int EVT_W = 2;
    localparam int EVT_DONE = 0;
    localparam int EVT_ABORT = 1;
    // converter clock cycles per conversion
    localparam int CONV_CYC = 13;
    localparam int INIT_CYC = 25;
    localparam logic [3:0] SRC_BANDGAP = 4'h8;
    localparam logic [3:0] SRC_GND = 4'h9;

    typedef enum logic [1:0] {
        GAIN_1X = 2'h0,
        GAIN_10X = 2'h1,
        GAIN_200X = 2'h2
    } adcmx_gain_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_HOLD = 2'b11
    } adcmx_state_t;

    typedef struct packed {
        logic [1:0] ref_code;
        logic int_ref_on;
        logic ext_ref;
        logic diff;
        logic [3:0] pos;
        logic [3:0] neg;
        adcmx_gain_t gain;
    } adcmx_sel_t;

    typedef struct packed {
        logic power;
        logic tick;
        logic start;
        logic init;
        adcmx_sel_t sel;
    } adcmx_core_t;
endpackage

// *** verilog/adcmx_ctrl.sv ***
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// - reference code 0 external pin, 1 supply, 2 reserved, 3 internal 2.56V.
// - reference and channel changes apply only after the running conversion completes.
// - result-adjust bit changes result presentation immediately, even mid-conversion.
// - channel codes 0-7 single-ended inputs, 11110 bandgap, 11111 ground.
// - codes 01000-11101 select differential pairs with 10x, 200x or 1x gain.
// - enable powers converter; clearing it powers off and aborts running conversion.
// - start bit begins a conversion; in free-running only the first one.
// - first conversion after enabling takes 25 converter clocks, others 13.
// - start bit reads one while converting; writing zero does nothing.
// - with auto trigger on, rising edge of selected source starts conversion.
// - completion flag sets when conversion ends and result is updated.
// - completion flag clears when the interrupt vector is taken.
// - writing one clears the completion flag; writing zero keeps it.
// - conversion interrupt needs flag, interrupt enable and global enable.
// - converter clock divides system clock by 2,2,4,8,16,32,64,128.
// - trigger source zero is free-running; switching to it triggers nothing.
// - adjust set gives left-aligned result, clear gives right-aligned.
// - after low byte read, result frozen until high byte is read.
module adcmx_ctrl
    import adcmx_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int INIT_CYCLES = INIT_CYC
)(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [7:0] trig_i,
    input wire logic [9:0] result_i,
    input wire logic gie_i,
    input wire logic irq_ack_i,
    output adcmx_core_t core_o,
    output logic conv_irq_o,
    output logic irq_o
);
    logic wr_ff, nxt_wr;
    logic [7:0] addr_ff, nxt_addr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic en_ff, nxt_en;
    logic ate_ff, nxt_ate;
    logic flag_ff, nxt_flag;
    logic ie_ff, nxt_ie;
    logic [2:0] ps_ff, nxt_ps;
    logic [7:0] mux_ff, nxt_mux;
    logic [2:0] ts_ff, nxt_ts;
    logic [EVT_W-1:0] evt_st_ff, nxt_evt_st;
    logic [EVT_W-1:0] evt_mk_ff, nxt_evt_mk;
    logic lock_ff, nxt_lock;
    adcmx_state_t state_ff, nxt_state;
    logic [4:0] cyc_ff, nxt_cyc;
    logic first_ff, nxt_first;
    logic init_ff, nxt_init;
    logic start_ff, nxt_start;
    logic [6:0] presc_ff, nxt_presc;
    logic trig_prev_ff, nxt_trig_prev;
    logic [9:0] samp_ff, nxt_samp;
    logic [9:0] result_ff, nxt_result;
    adcmx_sel_t sel_ff, nxt_sel;
    logic bus_take, wr_ctrl, wr_evt, start_wr, trig_edge;
    logic tick, conv_end, upd, go, abort;
    logic [7:0] wdat, ctrl_rd, res_lo, res_hi;
    logic [4:0] cyc_last;

    function automatic logic [6:0] div_mask(input logic [2:0] ps);
        div_mask = (ps <= 3'h1) ? 7'h01 : 7'((8'h01 << ps) - 8'h01);
    endfunction

    function automatic adcmx_sel_t dec_sel(input logic [7:0] m);
        adcmx_sel_t s;
        s = '0;
        s.ref_code = m[7:6];
        s.int_ref_on = (m[7:6] == REF_INT);
        s.ext_ref = (m[7:6] == REF_EXT);
        s.gain = GAIN_1X;
        case (m[4:3])
            2'b00: s.pos = {1'b0, m[2:0]};
            // 10x/200x pairs on inputs 0/1 and 2/3
            2'b01:
            begin
                s.diff = 1'b1;
                s.pos = {2'b00, m[2], m[0]};
                s.neg = {2'b00, m[2], 1'b0};
                s.gain = m[1] ? GAIN_200X : GAIN_10X;
            end
            2'b10:
            begin
                s.diff = 1'b1;
                s.pos = {1'b0, m[2:0]};
                s.neg = 4'h1;
            end
            default:
            begin
                if (m[2:1] == 2'b11)
                begin
                    s.pos = m[0] ? SRC_GND : SRC_BANDGAP;
                end
                else
                begin
                    s.diff = 1'b1;
                    s.pos = {1'b0, m[2:0]};
                    s.neg = 4'h2;
                end
            end
        endcase
        return s;
    endfunction

    assign wdat = hwdata_i[7:0];
    assign bus_take = hsel_i & htrans_i[1] & hready_i;
    assign wr_ctrl = wr_ff & (addr_ff == ADDR_CTRL);
    assign wr_evt = wr_ff & (addr_ff == ADDR_EVT_STAT);
    // start bit mirrors the busy state
    assign ctrl_rd = {en_ff, state_ff != ST_IDLE, ate_ff, flag_ff, ie_ff, ps_ff};
    // presentation follows the live adjust bit
    assign res_lo = mux_ff[MUX_ADJ] ? {result_ff[1:0], 6'h00} : result_ff[7:0];
    assign res_hi = mux_ff[MUX_ADJ] ? result_ff[9:2] : {6'h00, result_ff[9:8]};

    // registers, AHB-Lite slave; zero wait state, read data sampled in address phase
    always_comb
    begin
        nxt_wr = bus_take & hwrite_i;
        nxt_addr = bus_take ? haddr_i[7:0] : addr_ff;
        nxt_rdata = rdata_ff;
        nxt_lock = lock_ff;
        if (bus_take && !hwrite_i)
        begin
            nxt_rdata = 32'h0000_0000;
            case (haddr_i[7:0])
                ADDR_CTRL: nxt_rdata[7:0] = ctrl_rd;
                ADDR_MUX: nxt_rdata[7:0] = mux_ff;
                ADDR_TRIG: nxt_rdata[2:0] = ts_ff;
                ADDR_RES_LO: nxt_rdata[7:0] = res_lo;
                ADDR_RES_HI: nxt_rdata[7:0] = res_hi;
                ADDR_EVT_STAT: nxt_rdata[EVT_W-1:0] = evt_st_ff;
                ADDR_EVT_MASK: nxt_rdata[EVT_W-1:0] = evt_mk_ff;
                default: nxt_rdata = 32'h0000_0000;
            endcase
            // low read locks, high read releases
            if (haddr_i[7:0] == ADDR_RES_LO)
                nxt_lock = 1'b1;
            if (haddr_i[7:0] == ADDR_RES_HI)
                nxt_lock = 1'b0;
        end
        nxt_en = wr_ctrl ? wdat[CTRL_EN] : en_ff;
        nxt_ate = wr_ctrl ? wdat[CTRL_AUTO] : ate_ff;
        nxt_ie = wr_ctrl ? wdat[CTRL_IE] : ie_ff;
        nxt_ps = wr_ctrl ? wdat[2:0] : ps_ff;
        nxt_mux = (wr_ff && addr_ff == ADDR_MUX) ? wdat : mux_ff;
        nxt_ts = (wr_ff && addr_ff == ADDR_TRIG) ? wdat[2:0] : ts_ff;
        nxt_evt_mk = (wr_ff && addr_ff == ADDR_EVT_MASK) ? wdat[EVT_W-1:0] : evt_mk_ff;
        nxt_flag = upd | (flag_ff & ~(wr_ctrl & wdat[CTRL_FLAG]) & ~irq_ack_i);
        nxt_evt_st = evt_st_ff & ~(wr_evt ? wdat[EVT_W-1:0] : '0);
        nxt_evt_st[EVT_DONE] = nxt_evt_st[EVT_DONE] | upd;
        nxt_evt_st[EVT_ABORT] = nxt_evt_st[EVT_ABORT] | abort;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_ff <= 1'b0;
            addr_ff <= RST_BYTE;
            rdata_ff <= 32'h0000_0000;
            lock_ff <= 1'b0;
            en_ff <= 1'b0;
            ate_ff <= 1'b0;
            ie_ff <= 1'b0;
            ps_ff <= 3'h0;
            mux_ff <= RST_BYTE;
            ts_ff <= 3'h0;
            evt_mk_ff <= '0;
            flag_ff <= 1'b0;
            evt_st_ff <= '0;
        end
        else if (ce_i)
        begin
            wr_ff <= nxt_wr;
            addr_ff <= nxt_addr;
            rdata_ff <= nxt_rdata;
            lock_ff <= nxt_lock;
            en_ff <= nxt_en;
            ate_ff <= nxt_ate;
            ie_ff <= nxt_ie;
            ps_ff <= nxt_ps;
            mux_ff <= nxt_mux;
            ts_ff <= nxt_ts;
            evt_mk_ff <= nxt_evt_mk;
            flag_ff <= nxt_flag;
            evt_st_ff <= nxt_evt_st;
        end
    end

    // prescaler tick when the low bits of the counter are all ones
    assign tick = en_ff & ((presc_ff & div_mask(ps_ff)) == div_mask(ps_ff));
    // start write, enable may be set in the same write
    // a written zero never starts or stops anything
    assign start_wr = wr_ctrl & wdat[CTRL_START] & wdat[CTRL_EN];
    // edge of selected source; code zero never edges
    assign trig_edge = ate_ff & (ts_ff != TS_FREE) & trig_i[ts_ff] & ~trig_prev_ff;
    assign cyc_last = init_ff ? 5'(INIT_CYCLES - 1) : 5'(CONV_CYCLES - 1);
    assign conv_end = (state_ff == ST_CONV) & tick & (cyc_ff == cyc_last);
    assign upd = (state_ff == ST_HOLD) & ~lock_ff & nxt_en;
    assign abort = (state_ff != ST_IDLE) & ~nxt_en;
    assign go = ((state_ff == ST_IDLE) & nxt_en & (start_wr | trig_edge))
        | (upd & ate_ff & (ts_ff == TS_FREE));

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cyc = cyc_ff;
        nxt_init = init_ff;
        nxt_samp = conv_end ? result_i : samp_ff;
        nxt_result = upd ? samp_ff : result_ff;
        nxt_presc = en_ff ? presc_ff + 7'h01 : 7'h00;
        nxt_trig_prev = trig_i[ts_ff];
        nxt_start = go;
        // init pending while disabled, consumed by a start
        nxt_first = ~nxt_en | (first_ff & ~go);
        // selection frozen from start to completion
        nxt_sel = (state_ff == ST_IDLE || upd) ? dec_sel(mux_ff) : sel_ff;
        case (state_ff)
            ST_IDLE: nxt_state = go ? ST_CONV : state_ff;
            ST_CONV:
            begin
                if (tick)
                begin
                    nxt_cyc = cyc_ff + 5'h01;
                end
                if (conv_end)
                begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                // completion waits for the high byte read while the result is locked
                if (upd)
                    nxt_state = go ? ST_CONV : ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
        if (go)
        begin
            nxt_cyc = 5'h00;
            nxt_init = first_ff;
        end
        if (abort)
            nxt_state = ST_IDLE;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= ST_IDLE;
            cyc_ff <= 5'h00;
            init_ff <= 1'b0;
            first_ff <= 1'b1;
            start_ff <= 1'b0;
            samp_ff <= 10'h000;
            result_ff <= 10'h000;
            presc_ff <= 7'h00;
            trig_prev_ff <= 1'b0;
            sel_ff <= '0;
        end
        else if (ce_i)
        begin
            state_ff <= nxt_state;
            cyc_ff <= nxt_cyc;
            init_ff <= nxt_init;
            first_ff <= nxt_first;
            start_ff <= nxt_start;
            samp_ff <= nxt_samp;
            result_ff <= nxt_result;
            presc_ff <= nxt_presc;
            trig_prev_ff <= nxt_trig_prev;
            sel_ff <= nxt_sel;
        end
    end

    assign hrdata_o = rdata_ff;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign core_o = '{power: en_ff, tick: tick, start: start_ff, init: init_ff, sel: sel_ff};
    assign conv_irq_o = flag_ff & ie_ff & gie_i;
    assign irq_o = |(evt_st_ff & evt_mk_ff);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_disable_aborts: assert property (
        ce_i && state_ff != ST_IDLE && wr_ctrl && !wdat[CTRL_EN] |=> state_ff == ST_IDLE)
        else $error("disable did not abort");
    a_flag_on_update: assert property (
        ce_i && upd |=> flag_ff && result_ff == $past(samp_ff))
        else $error("flag or result missing at update");
    a_flag_w1c: assert property (
        ce_i && flag_ff && wr_ctrl && wdat[CTRL_FLAG] && !upd |=> !flag_ff)
        else $error("write one did not clear flag");
    a_zero_keeps_flag: assert property (
        ce_i && flag_ff && wr_ctrl && !wdat[CTRL_FLAG] && !irq_ack_i |=> flag_ff)
        else $error("write zero cleared flag");
    a_ack_clears: assert property (
        ce_i && irq_ack_i && !upd |=> !flag_ff)
        else $error("vector ack did not clear flag");
    a_irq_gate: assert property (
        conv_irq_o |-> flag_ff && ie_ff && gie_i)
        else $error("interrupt without all enables");
    a_sel_frozen: assert property (
        state_ff == ST_CONV && $past(state_ff) == ST_CONV |-> $stable(sel_ff))
        else $error("selection changed mid conversion");
    a_conv_length: assert property (
        state_ff == ST_CONV |-> cyc_ff <= (init_ff ? 5'(INIT_CYCLES - 1) : 5'(CONV_CYCLES - 1)))
        else $error("conversion ran too long");
    a_tick_spacing: assert property (
        ce_i && tick |=> !tick)
        else $error("converter clock faster than half");
    a_lock_holds: assert property (
        ce_i && lock_ff && state_ff == ST_HOLD |=> $stable(result_ff) && state_ff != ST_CONV)
        else $error("result updated while locked");
    a_free_no_trig: assert property (
        ce_i && state_ff == ST_IDLE && ts_ff == TS_FREE && !start_wr |=> state_ff == ST_IDLE)
        else $error("free-running select triggered");
    a_start_busy: assert property (
        ce_i && state_ff == ST_IDLE && start_wr |=> ctrl_rd[CTRL_START])
        else $error("start bit not reading busy");

    c_free_run: cover property (upd && go);
    c_abort: cover property (abort);
    c_init_done: cover property (conv_end && init_ff);
    c_locked_hold: cover property (state_ff == ST_HOLD && lock_ff);
endmodule

// *** sim/adcmx_core_model.sv ***
`timescale 1ns/100ps
module adcmx_core_model
    import adcmx_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire adcmx_core_t core_i,
    output logic [9:0] result_o,
    output logic [5:0] n_conv_o
);
    // result carries a serial number and the channel, so stale data shows
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            n_conv_o <= 6'h00;
            result_o <= 10'h155;
        end
        else if (core_i.start)
        begin
            n_conv_o <= n_conv_o + 6'h01;
            result_o <= {n_conv_o + 6'h01, core_i.sel.pos};
        end
        // powered down core output is meaningless, keep it moving
        else if (!core_i.power)
            result_o <= ~result_o;
    end
endmodule

// *** sim/adcmx_ctrl_tb.sv ***
`timescale 1ns/100ps
module adcmx_ctrl_tb
    import adcmx_pkg::*;
;
    logic clk, rst_n, hsel, hwrite, gie, ack, hrdy, hresp, conv_irq, irq;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [7:0] trig, m;
    logic [9:0] result, r;
    logic [5:0] n_conv;
    adcmx_core_t core;
    adcmx_sel_t e, s;
    int n_mismatch, compares, cyc, n_start, t0, n, s0;

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (core.start === 1'b1)
            n_start <= n_start + 1;
    end

    adcmx_ctrl #(.CONV_CYCLES(4), .INIT_CYCLES(9)) i_dut (.clk_i(clk), .rst_n_i(rst_n),
        .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
        .hreadyout_o(hrdy), .hresp_o(hresp), .trig_i(trig), .result_i(result), .gie_i(gie),
        .irq_ack_i(ack), .core_o(core), .conv_irq_o(conv_irq), .irq_o(irq));
    adcmx_core_model i_core (.clk_i(clk), .rst_n_i(rst_n), .core_i(core),
        .result_o(result), .n_conv_o(n_conv));

    task automatic print_verdict();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic chk_in(input int v, input int lo, input int hi);
        compares++;
        if (v < lo || v > hi)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask
    task automatic chk_lvl(ref logic x, input logic v);
        @(negedge clk);
        chk(32'(x), 32'(v));
    endtask
    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge clk);
        while (hrdy !== 1'b1)
        begin
            k++;
            if (k > 50)
            begin
                n_mismatch++;
                print_verdict();
            end
            @(posedge clk);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        rdata = hrdata;
    endtask
    // n is measured from t0, the edge that decided the start
    task automatic wait_done();
        int k;
        k = 0;
        @(negedge clk);
        while (conv_irq !== 1'b1)
        begin
            k++;
            if (k > 3000)
            begin
                n_mismatch++;
                print_verdict();
            end
            @(negedge clk);
        end
        n = cyc - t0;
    endtask
    task automatic tick_gap(output int g);
        int k;
        k = 0;
        g = 1;
        @(negedge clk);
        while (core.tick !== 1'b1 && k < 300)
        begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        while (core.tick !== 1'b1 && g < 300)
        begin
            @(negedge clk);
            g++;
        end
    endtask
    task automatic chk_res(input logic [9:0] v, input logic adj);
        bus(ADDR_RES_LO, 1'b0, 8'h00);
        chk(rdata, adj ? {24'h0, v[1:0], 6'h0} : {24'h0, v[7:0]});
        bus(ADDR_RES_HI, 1'b0, 8'h00);
        chk(rdata, adj ? {24'h0, v[9:2]} : {30'h0, v[9:8]});
    endtask
    task automatic pulse_ack();
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
    endtask
    function automatic adcmx_sel_t exp_sel(input logic [7:0] v);
        adcmx_sel_t x;
        logic [4:0] c;
        c = v[4:0];
        x = '0;
        x.ref_code = v[7:6];
        x.int_ref_on = (v[7:6] == REF_INT);
        x.ext_ref = (v[7:6] == REF_EXT);
        x.gain = GAIN_1X;
        x.diff = (c > 5'h07) && (c < 5'h1e);
        if (c < 5'h08)
            x.pos = {1'b0, c[2:0]};
        else if (c == 5'h1e)
            x.pos = SRC_BANDGAP;
        else if (c == 5'h1f)
            x.pos = SRC_GND;
        else if (c < 5'h10)
        begin
            x.pos = {2'h0, c[2], c[0]};
            x.neg = {2'h0, c[2], 1'b0};
            x.gain = c[1] ? GAIN_200X : GAIN_10X;
        end
        else
        begin
            x.pos = {1'b0, c[2:0]};
            x.neg = c[3] ? 4'h2 : 4'h1;
        end
        return x;
    endfunction

    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        trig = 8'h00;
        gie = 1'b1;
        ack = 1'b0;
        {cyc, n_start, n_mismatch, compares} = '0;
        n = $urandom(32'h8dfe);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // the last address is unmapped
        for (int a = 0; a < 8; a++)
        begin
            bus(8'(a * 4), 1'b0, 8'h00);
            chk(rdata, 32'h0);
        end
        chk(32'(hresp), 32'h0);
        $display("test reset done");
        for (int c = 0; c < 32; c++)
        begin
            m = {2'($urandom), 1'($urandom), 5'(c)};
            bus(ADDR_MUX, 1'b1, m);
            bus(ADDR_MUX, 1'b0, 8'h00);
            chk(rdata, {24'h0, m});
            e = exp_sel(m);
            s = core.sel;
            if (!e.diff)
                s.neg = e.neg;
            chk(32'(s), 32'(e));
        end
        $display("test select done");
        for (int p = 0; p < 8; p++)
        begin
            bus(ADDR_CTRL, 1'b1, 8'h80 | 8'(p));
            tick_gap(n);
            chk(32'(n), p < 2 ? 32'h2 : 32'h1 << p);
        end
        bus(ADDR_CTRL, 1'b1, 8'h00);
        $display("test prescaler done");
        bus(ADDR_MUX, 1'b1, 8'h01);
        bus(ADDR_CTRL, 1'b1, 8'hca);
        t0 = cyc;
        @(negedge clk);
        chk(32'(core.init), 32'h1);
        chk(32'(core.power), 32'h1);
        bus(ADDR_CTRL, 1'b0, 8'h00);
        chk(rdata, 32'hca);
        bus(ADDR_MUX, 1'b1, 8'h23);
        bus(ADDR_CTRL, 1'b1, 8'h8a);
        chk(32'(core.sel.pos), 32'h1);
        wait_done();
        chk_in(n, 32, 39);
        r = {n_conv, 4'h1};
        repeat (2) @(negedge clk);
        chk(32'(core.sel.pos), 32'h3);
        bus(ADDR_CTRL, 1'b0, 8'h00);
        chk(rdata, 32'h9a);
        chk_res(r, 1'b1);
        bus(ADDR_RES_LO, 1'b0, 8'h00);
        bus(ADDR_CTRL, 1'b1, 8'hda);
        chk_lvl(conv_irq, 1'b0);
        repeat (60) @(negedge clk);
        chk(32'(conv_irq), 32'h0);
        bus(ADDR_RES_HI, 1'b0, 8'h00);
        chk(rdata, {24'h0, r[9:2]});
        wait_done();
        r = {n_conv, 4'h3};
        chk_res(r, 1'b1);
        bus(ADDR_CTRL, 1'b1, 8'hda);
        t0 = cyc;
        bus(ADDR_MUX, 1'b1, 8'h03);
        bus(ADDR_RES_HI, 1'b0, 8'h00);
        chk(rdata, {30'h0, r[9:8]});
        chk(32'(core.init), 32'h0);
        wait_done();
        chk_in(n, 12, 19);
        $display("test conversion done");
        bus(ADDR_CTRL, 1'b1, 8'h8a);
        chk_lvl(conv_irq, 1'b1);
        @(posedge clk);
        gie <= 1'b0;
        chk_lvl(conv_irq, 1'b0);
        @(posedge clk);
        gie <= 1'b1;
        bus(ADDR_CTRL, 1'b1, 8'h82);
        chk_lvl(conv_irq, 1'b0);
        bus(ADDR_CTRL, 1'b1, 8'h8a);
        chk_lvl(conv_irq, 1'b1);
        pulse_ack();
        bus(ADDR_CTRL, 1'b0, 8'h00);
        chk(rdata, 32'h8a);
        $display("test flag done");
        bus(ADDR_EVT_STAT, 1'b1, 8'h03);
        bus(ADDR_EVT_MASK, 1'b1, 8'h03);
        bus(ADDR_CTRL, 1'b1, 8'hca);
        bus(ADDR_CTRL, 1'b1, 8'h0a);
        @(negedge clk);
        chk(32'(core.power), 32'h0);
        bus(ADDR_CTRL, 1'b0, 8'h00);
        chk(rdata, 32'h0a);
        bus(ADDR_EVT_STAT, 1'b0, 8'h00);
        chk(rdata, 32'h2);
        chk_lvl(irq, 1'b1);
        bus(ADDR_EVT_MASK, 1'b1, 8'h01);
        chk_lvl(irq, 1'b0);
        bus(ADDR_EVT_MASK, 1'b1, 8'h02);
        bus(ADDR_EVT_STAT, 1'b1, 8'h02);
        chk_lvl(irq, 1'b0);
        $display("test abort done");
        bus(ADDR_TRIG, 1'b1, 8'h05);
        bus(ADDR_CTRL, 1'b1, 8'haa);
        s0 = n_start;
        // noise on the other sources must not start anything
        repeat (20)
        begin
            @(posedge clk);
            trig <= 8'($urandom) & 8'hdf;
        end
        chk(32'(n_start - s0), 32'h0);
        @(posedge clk);
        trig <= 8'h20;
        wait_done();
        chk(32'(n_start - s0), 32'h1);
        bus(ADDR_TRIG, 1'b1, 8'h00);
        repeat (40) @(negedge clk);
        chk(32'(n_start - s0), 32'h1);
        bus(ADDR_CTRL, 1'b1, 8'hfa);
        wait_done();
        pulse_ack();
        wait_done();
        repeat (4) @(posedge clk);
        chk(32'(n_start - s0), 32'h4);
        bus(ADDR_CTRL, 1'b1, 8'h00);
        $display("test trigger done");
        print_verdict();
    end
endmodule
